// file: hw/chg_seq_pkg.sv
/*
  constants, states and carrier types for the charger enable sequencer.
  assumes a single 40 MHz clock; shared by the sequencer, its hold-off timer and the bench.
*/
package chg_seq_pkg;

  // ----------------------------------------------------------------
  // clock and hold-off timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 25000;     // 40 MHz clock
  localparam int PERMIT_HOLDOFF_US = 100;   // restart block after permit drops
  localparam int DETACH_HOLDOFF_US = 100;   // restart block after detach
  localparam int HOLDOFF_W = 12;            // hold-off counter width
  // least times: round up to whole cycles
  localparam logic [HOLDOFF_W-1:0] PERMIT_HOLDOFF_CYC =
    HOLDOFF_W'((PERMIT_HOLDOFF_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam logic [HOLDOFF_W-1:0] DETACH_HOLDOFF_CYC =
    HOLDOFF_W'((DETACH_HOLDOFF_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);

  // ----------------------------------------------------------------
  // register map (word index on the avalon address)
  // ----------------------------------------------------------------
  localparam int ADDR_W = 2;
  localparam logic [ADDR_W-1:0] REG_CTRL = 2'h0;    // byte offset 0x0
  localparam logic [ADDR_W-1:0] REG_STATUS = 2'h1;  // byte offset 0x4
  localparam int CTRL_SETUP_DONE = 0;               // setup-done bit
  localparam int CTRL_SOFT_EN = 1;                  // converter_soft_enable_bit
  localparam int CTRL_BYPASS = 2;                   // typec_bypass_bit
  localparam logic CTRL_SETUP_DONE_RST = 1'h0;
  localparam logic CTRL_SOFT_EN_RST = 1'h0;
  localparam logic CTRL_BYPASS_RST = 1'h0;
  localparam int SYNC_STAGES = 3;                   // pin synchroniser depth

  // ----------------------------------------------------------------
  // sequencer states and charge levels
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_OFF = 2'b00,       // system enable low or rail under threshold
    ST_UNCONFIG = 2'b01,  // alive, waiting for setup-done
    ST_IDLE = 2'b10,      // configured, waiting for attach/permit/hold-off
    ST_RUN = 2'b11        // converter and gate drive on
  } seq_state_t;

  typedef enum logic [2:0] {
    LVL_USB2 = 3'h0,      // default 500 mA
    LVL_USB3 = 3'h1,      // default 900 mA
    LVL_BC12 = 3'h2,      // battery-charging detection, up to 1.5 A
    LVL_C1P5 = 3'h3,      // type-c 1.5 A advertisement
    LVL_C3A = 3'h4        // type-c 3 A advertisement
  } charge_level_t;

  // status word carried to the read mux
  typedef struct packed {
    charge_level_t level; // bits 10:8
    logic [0:0] spare;    // bit 7, reads zero
    logic regulator_on;   // bit 6
    logic holdoff_busy;   // bit 5
    logic unconfigured;   // bit 4
    logic attached;       // bit 3
    logic fet_on;         // bit 2
    logic converter_run;  // bit 1
    logic permit;         // bit 0
  } status_t;

endpackage : chg_seq_pkg

// file: hw/pin_sync3.sv
/*
  three-stage synchroniser for a group of asynchronous pin levels.
  assumes each bit is an independent level; a change is accepted once the
  second and third stages agree.
*/
`timescale 1ns/1ps
module pin_sync3 #(
  parameter int WIDTH = 1
) (
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic [WIDTH-1:0] pin_i,
  output logic [WIDTH-1:0] level_o
);

  logic [WIDTH-1:0] s1_r;  // metastability stage, read only by s2_r
  logic [WIDTH-1:0] s2_r;
  logic [WIDTH-1:0] s3_r;

  // ----------------------------------------------------------------
  // shift chain
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
    end else begin
      s1_r <= pin_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // accept a bit only when the two settled stages agree
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      level_o <= '0;
    end else begin
      for (int i = 0; i < WIDTH; i++) begin
        if (s2_r[i] == s3_r[i]) begin
          level_o[i] <= s3_r[i];
        end
      end
    end
  end

endmodule : pin_sync3

// file: hw/holdoff_timer.sv
/*
  restart hold-off timer: loads a cycle count on a trigger and reports busy
  until it has counted down. assumes the trigger is a same-clock pulse.
*/
`timescale 1ns/1ps
module holdoff_timer (
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic fire_i,
  input wire logic [chg_seq_pkg::HOLDOFF_W-1:0] count_i,
  output logic busy_o
);

  logic [chg_seq_pkg::HOLDOFF_W-1:0] cnt_r;  // cycles left

  // ----------------------------------------------------------------
  // countdown; a new trigger restarts the full wait
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      cnt_r <= '0;
    end else if (fire_i) begin
      cnt_r <= count_i;
    end else if (cnt_r != '0) begin
      cnt_r <= cnt_r - 1'b1;
    end
  end

  assign busy_o = (cnt_r != '0);

endmodule : holdoff_timer

// file: hw/charger_enable_sequencer.sv
/*
  enable and power-up gating of a type-c charging port: decides when the
  internal regulator, the step-down converter and the external fet gate
  drive may run. assumes asynchronous pins, same-clock capability inputs
  from the type-c and charger-detect logic, and an avalon-mm master.
*/
// Notes on behaviour
// - system enable low means low-power standby
// - any system reset raises unconfigured interrupt in the serial variant; resistor variant int_n is the attach flag
// - converter waits for setup-done then attach
// - permit is pin AND software enable
// - resistor variant forces software enable high
// - pin low overrides software enable command
// - no attach means fet and converter off
// - bypass bit skips type-c attach machine
// - rail undervoltage keeps control logic disabled
// - regulator follows system enable and supply
// - charge level priority: 3A, 1.5A, BC, default
// - legacy adapter termination counts as attach
// - pin low at enable keeps converter off
// - detach or permit drop starts hold-off
`timescale 1ns/1ps
module charger_enable_sequencer (
  input wire logic clock_i,
  input wire logic resetn_i,
  // pins and analog comparators, asynchronous
  input wire logic system_enable_pin_i,
  input wire logic converter_enable_pin_i,
  input wire logic supply_above_uv_i,
  input wire logic rail_above_uv_i,
  input wire logic cc_sink_detect_i,
  input wire logic variant_serial_i,
  // capability inputs, same clock
  input wire logic adv_3a_i,
  input wire logic adv_1p5_i,
  input wire logic bc_detect_i,
  input wire logic usb3_i,
  // avalon-mm slave
  input wire logic [chg_seq_pkg::ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // controls and status
  output logic regulator_on_o,
  output logic standby_o,
  output logic converter_permit_o,
  output logic converter_run_o,
  output logic ext_fet_gate_drive_o,
  output logic int_n_o,
  output chg_seq_pkg::charge_level_t charge_level_o
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [5:0] pins_s;  // settled pin levels
  logic en_s;          // system enable
  logic cen_s;         // converter enable pin
  logic supply_s;      // main supply above threshold
  logic rail_s;        // internal rail above threshold
  logic attach_s;      // sink termination seen on cc
  logic strap_s;       // serial variant strap

  pin_sync3 #(
    .WIDTH(6)
  ) u_sync (
    .clock_i(clock_i),
    .resetn_i(resetn_i),
    .pin_i({variant_serial_i, cc_sink_detect_i, rail_above_uv_i,
            supply_above_uv_i, converter_enable_pin_i, system_enable_pin_i}),
    .level_o(pins_s)
  );

  assign en_s = pins_s[0];
  assign cen_s = pins_s[1];
  assign supply_s = pins_s[2];
  assign rail_s = pins_s[3];
  assign attach_s = pins_s[4];
  assign strap_s = pins_s[5];

  // ----------------------------------------------------------------
  // system alive and regulator
  // ----------------------------------------------------------------
  logic alive_r;   // control logic may act
  logic serial_r;  // variant caught while held in system reset

  // the rail is only trusted once enable and its own comparator agree
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      alive_r <= 1'b0;
    end else begin
      alive_r <= en_s & rail_s;
    end
  end

  // strap is re-caught during every system reset, never under resetn
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      serial_r <= 1'b0;
    end else if (!alive_r) begin
      serial_r <= strap_s;
    end
  end

  // regulator and standby indication
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      regulator_on_o <= 1'b0;
      standby_o <= 1'b1;
    end else begin
      regulator_on_o <= en_s & supply_s;
      standby_o <= ~alive_r;
    end
  end

  // ----------------------------------------------------------------
  // avalon slave: one wait state on every access
  // ----------------------------------------------------------------
  logic wait_r;      // drives waitrequest
  logic req;         // read or write pending
  logic wr_take;     // write commits this edge
  logic setup_done_r;
  logic soft_en_r;
  logic bypass_r;
  logic unconfig_r;
  chg_seq_pkg::status_t status;

  assign req = avs_read_i | avs_write_i;
  assign wr_take = avs_write_i & ~wait_r;
  assign avs_waitrequest_o = wait_r;

  // drop waitrequest one cycle after a request, raise it right after
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      wait_r <= 1'b1;
    end else if (req && wait_r) begin
      wait_r <= 1'b0;
    end else begin
      wait_r <= 1'b1;
    end
  end

  // read data settle in the cycle waitrequest is low
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      avs_readdata_o <= 32'h0;
    end else if (avs_read_i && wait_r) begin
      case (avs_address_i)
        chg_seq_pkg::REG_CTRL: begin
          avs_readdata_o <= {29'h0, bypass_r, soft_en_r, setup_done_r};
        end
        chg_seq_pkg::REG_STATUS: begin
          avs_readdata_o <= {21'h0, status};
        end
        default: begin
          avs_readdata_o <= 32'h0;  // unmapped reads zero
        end
      endcase
    end
  end

  // control bits; any system reset wipes the configuration
  always_ff @(posedge clock_i) begin
    if (!resetn_i || !alive_r) begin
      setup_done_r <= chg_seq_pkg::CTRL_SETUP_DONE_RST;
      soft_en_r <= chg_seq_pkg::CTRL_SOFT_EN_RST;
      bypass_r <= chg_seq_pkg::CTRL_BYPASS_RST;
    end else if (wr_take && avs_address_i == chg_seq_pkg::REG_CTRL) begin
      setup_done_r <= avs_writedata_i[chg_seq_pkg::CTRL_SETUP_DONE];
      soft_en_r <= avs_writedata_i[chg_seq_pkg::CTRL_SOFT_EN];
      bypass_r <= avs_writedata_i[chg_seq_pkg::CTRL_BYPASS];
    end
  end

  // unconfigured flag: system reset sets it and wins over the clear
  always_ff @(posedge clock_i) begin
    if (!resetn_i || !alive_r) begin
      unconfig_r <= 1'b1;
    end else if (wr_take && avs_address_i == chg_seq_pkg::REG_CTRL &&
                 avs_writedata_i[chg_seq_pkg::CTRL_SETUP_DONE]) begin
      unconfig_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // permit and attach terms
  // ----------------------------------------------------------------
  logic setup_ok;     // configuration complete
  logic soft_term;    // software half of the permit
  logic pin_armed_r;  // pin seen high since system enable
  logic permit_r;     // converter permit
  logic attach_eff;   // attach as the sequencer sees it

  // the resistor variant has no software path, so it needs no setup write
  assign setup_ok = serial_r ? setup_done_r : 1'b1;
  assign soft_term = serial_r ? soft_en_r : 1'b1;
  // bypass is reachable only through the serial registers
  assign attach_eff = (serial_r && bypass_r) ? 1'b1 : attach_s;

  // pin low at enable keeps the arm cleared until the pin goes high
  always_ff @(posedge clock_i) begin
    if (!resetn_i || !alive_r) begin
      pin_armed_r <= 1'b0;
    end else if (cen_s) begin
      pin_armed_r <= 1'b1;
    end
  end

  // pin low overrides any software command in either variant
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      permit_r <= 1'b0;
    end else begin
      permit_r <= alive_r & pin_armed_r & cen_s & soft_term;
    end
  end

  // ----------------------------------------------------------------
  // restart hold-off timers
  // ----------------------------------------------------------------
  logic attach_prev_r;
  logic permit_prev_r;
  logic det_fire;
  logic perm_fire;
  logic det_busy;
  logic perm_busy;

  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      attach_prev_r <= 1'b0;
      permit_prev_r <= 1'b0;
    end else begin
      attach_prev_r <= attach_eff;
      permit_prev_r <= permit_r;
    end
  end

  assign det_fire = attach_prev_r & ~attach_eff;
  assign perm_fire = permit_prev_r & ~permit_r;

  holdoff_timer u_det_hold (
    .clock_i(clock_i),
    .resetn_i(resetn_i),
    .fire_i(det_fire),
    .count_i(chg_seq_pkg::DETACH_HOLDOFF_CYC),
    .busy_o(det_busy)
  );

  holdoff_timer u_perm_hold (
    .clock_i(clock_i),
    .resetn_i(resetn_i),
    .fire_i(perm_fire),
    .count_i(chg_seq_pkg::PERMIT_HOLDOFF_CYC),
    .busy_o(perm_busy)
  );

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  chg_seq_pkg::seq_state_t state_r;
  chg_seq_pkg::seq_state_t state_nxt;
  logic go;  // setup, permit and attach all met

  assign go = setup_ok & permit_r & attach_eff;

  // next state; losing alive always returns to off
  always_comb begin
    state_nxt = state_r;
    if (!alive_r) begin
      state_nxt = chg_seq_pkg::ST_OFF;
    end else begin
      case (state_r)
        chg_seq_pkg::ST_OFF: begin
          state_nxt = setup_ok ? chg_seq_pkg::ST_IDLE : chg_seq_pkg::ST_UNCONFIG;
        end
        chg_seq_pkg::ST_UNCONFIG: begin
          if (setup_ok) begin
            state_nxt = chg_seq_pkg::ST_IDLE;
          end
        end
        chg_seq_pkg::ST_IDLE: begin
          if (go && !det_busy && !perm_busy) begin
            state_nxt = chg_seq_pkg::ST_RUN;
          end
        end
        chg_seq_pkg::ST_RUN: begin
          if (!go) begin
            state_nxt = chg_seq_pkg::ST_IDLE;
          end
        end
        default: begin
          state_nxt = chg_seq_pkg::ST_OFF;
        end
      endcase
    end
  end

  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      state_r <= chg_seq_pkg::ST_OFF;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // gate drive isolates the bulk capacitance whenever vbus is not sourced
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      converter_run_o <= 1'b0;
      ext_fet_gate_drive_o <= 1'b0;
      converter_permit_o <= 1'b0;
    end else begin
      converter_run_o <= (state_nxt == chg_seq_pkg::ST_RUN);
      ext_fet_gate_drive_o <= (state_nxt == chg_seq_pkg::ST_RUN);
      converter_permit_o <= permit_r;
    end
  end

  // serial variant: interrupt; resistor variant: active-low attach flag
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      int_n_o <= 1'b1;
    end else begin
      int_n_o <= serial_r ? ~unconfig_r : ~attach_eff;
    end
  end

  // capability resolved by fixed priority while sourcing
  always_ff @(posedge clock_i) begin
    if (!resetn_i || state_nxt != chg_seq_pkg::ST_RUN) begin
      charge_level_o <= chg_seq_pkg::LVL_USB2;
    end else if (adv_3a_i) begin
      charge_level_o <= chg_seq_pkg::LVL_C3A;
    end else if (adv_1p5_i) begin
      charge_level_o <= chg_seq_pkg::LVL_C1P5;
    end else if (bc_detect_i) begin
      charge_level_o <= chg_seq_pkg::LVL_BC12;
    end else begin
      charge_level_o <= usb3_i ? chg_seq_pkg::LVL_USB3 : chg_seq_pkg::LVL_USB2;
    end
  end

  // status word for software
  always_comb begin
    status = '0;
    status.level = charge_level_o;
    status.regulator_on = regulator_on_o;
    status.holdoff_busy = det_busy | perm_busy;
    status.unconfigured = unconfig_r;
    status.attached = attach_eff;
    status.fet_on = ext_fet_gate_drive_o;
    status.converter_run = converter_run_o;
    status.permit = permit_r;
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!resetn_i);

  property p_standby;
    !en_s |=> !regulator_on_o ##1 standby_o;
  endproperty
  a_standby: assert property (p_standby) else $error("no standby after enable low");

  property p_unconfig;
    (!alive_r ##1 serial_r) |=> !int_n_o;
  endproperty
  a_unconfig: assert property (p_unconfig) else $error("interrupt not raised after reset");

  property p_setup_attach;
    converter_run_o |-> $past(setup_ok) && $past(attach_eff);
  endproperty
  a_setup_attach: assert property (p_setup_attach) else $error("run without setup and attach");

  property p_permit;
    converter_run_o |-> $past(permit_r);
  endproperty
  a_permit: assert property (p_permit) else $error("run without permit");

  property p_pin_override;
    (serial_r && !cen_s) |=> !permit_r ##1 !converter_run_o;
  endproperty
  a_pin_override: assert property (p_pin_override) else $error("pin low did not disable");

  property p_detached;
    !attach_eff |=> !ext_fet_gate_drive_o && !converter_run_o;
  endproperty
  a_detached: assert property (p_detached) else $error("sourcing while detached");

  property p_rail;
    !rail_s |=> ##1 !converter_run_o;
  endproperty
  a_rail: assert property (p_rail) else $error("run with rail low");

  property p_arm;
    !pin_armed_r |=> !permit_r;
  endproperty
  a_arm: assert property (p_arm) else $error("permit before pin armed");

  property p_det_hold;
    det_fire |=> (det_busy && !converter_run_o) [*8];
  endproperty
  a_det_hold: assert property (p_det_hold) else $error("detach hold-off missing");

  property p_run;
    state_r == chg_seq_pkg::ST_IDLE ##1 converter_run_o;
  endproperty
  c_run: cover property (p_run);

  property p_detach_seen;
    converter_run_o ##1 det_fire;
  endproperty
  c_detach_seen: cover property (p_detach_seen);

  property p_configured;
    unconfig_r ##1 !unconfig_r;
  endproperty
  c_configured: cover property (p_configured);

endmodule : charger_enable_sequencer

// file: dv/host_model.sv
/*
  system controller model: avalon-mm master that configures the sequencer.
  assumes the slave answers with waitrequest low; the bench calls xfer.
*/
`timescale 1ns/1ps
module host_model (
  input wire logic clock_i,
  input wire logic waitrequest_i,
  input wire logic [31:0] readdata_i,
  output logic [chg_seq_pkg::ADDR_W-1:0] address_o,
  output logic read_o,
  output logic write_o,
  output logic [31:0] writedata_o
);
  // ----------------------------------------
  // bus cycle
  // ----------------------------------------
  initial begin
    address_o = '0;
    read_o = 1'b0;
    write_o = 1'b0;
    writedata_o = '0;
  end

  // one transfer; held until waitrequest low, then released with bus lines inverted
  // so a slave that samples late sees garbage, not a stale copy
  // no cycle limit here: a lost answer is left to the bench watchdog
  task automatic xfer(input logic wr, input logic [1:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clock_i);
    address_o <= a;
    writedata_o <= d;
    write_o <= wr;
    read_o <= !wr;
    do begin
      @(posedge clock_i);
    end while (waitrequest_i !== 1'b0);
    q = readdata_i; // read data stand at the edge that sees waitrequest low
    read_o <= 1'b0;
    write_o <= 1'b0;
    address_o <= ~a;
    writedata_o <= ~d;
  endtask : xfer

  // setup-done is written only once configuration is complete
  task automatic configure(input logic [31:0] ctrl);
    logic [31:0] q;
    xfer(1'b1, chg_seq_pkg::REG_CTRL, ctrl, q);
  endtask : configure
endmodule : host_model

// file: dv/tb.sv
/*
  self-checking bench for the charger enable sequencer.
  assumes the host model in dv/host_model.sv and the package in hw/.
*/
`timescale 1ns/1ps
module tb;
  // ----------------------------------------
  // stimulus and observation
  // ----------------------------------------
  logic clock_i = 1'b0;
  logic resetn_i = 1'b0;
  logic sen = 1'b0, cen = 1'b0, sup = 1'b1, rail = 1'b1, cc = 1'b0, ser = 1'b1; // pins
  logic a3 = 1'b0, a15 = 1'b0, bc = 1'b0, u3 = 1'b0; // capability levels
  logic [1:0] adr;
  logic rd, wr, wreq;
  logic [31:0] wdat, rdat, q;
  logic reg_on, stby, permit, run, fet, int_n;
  chg_seq_pkg::charge_level_t lvl;
  int n_fail = 0, num_checks = 0, n;

  always #12.5 clock_i = ~clock_i; // 40 MHz

  host_model host (.clock_i(clock_i), .waitrequest_i(wreq), .readdata_i(rdat), .address_o(adr),
    .read_o(rd), .write_o(wr), .writedata_o(wdat));

  charger_enable_sequencer DUT (.clock_i(clock_i), .resetn_i(resetn_i), .system_enable_pin_i(sen),
    .converter_enable_pin_i(cen), .supply_above_uv_i(sup), .rail_above_uv_i(rail),
    .cc_sink_detect_i(cc), .variant_serial_i(ser), .adv_3a_i(a3), .adv_1p5_i(a15), .bc_detect_i(bc),
    .usb3_i(u3), .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdat),
    .avs_readdata_o(rdat), .avs_waitrequest_o(wreq), .regulator_on_o(reg_on), .standby_o(stby),
    .converter_permit_o(permit), .converter_run_o(run), .ext_fet_gate_drive_o(fet), .int_n_o(int_n),
    .charge_level_o(lvl));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t %s", $time, m);
    end
  endtask : chk

  // sample at the falling edge so every registered output has settled
  task automatic tick(input int k);
    repeat (k) @(posedge clock_i);
    @(negedge clock_i);
  endtask : tick

  // cycles until run reaches v, bounded so a stuck converter cannot hang the run
  task automatic wait_run(input logic v, output int c);
    c = 0;
    while (run !== v && c < 5000) begin
      tick(1);
      c++;
    end
  endtask : wait_run

  // highest advertised capability wins
  function automatic logic [2:0] lvl_exp(input logic [3:0] c);
    if (c[3]) return chg_seq_pkg::LVL_C3A;
    if (c[2]) return chg_seq_pkg::LVL_C1P5;
    if (c[1]) return chg_seq_pkg::LVL_BC12;
    return c[0] ? chg_seq_pkg::LVL_USB3 : chg_seq_pkg::LVL_USB2;
  endfunction : lvl_exp

  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : complete_run

  // ----------------------------------------
  // watchdog: the sequence needs about 20k cycles
  // ----------------------------------------
  initial begin
    repeat (80000) @(posedge clock_i);
    n_fail++;
    complete_run();
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    logic [3:0] c;
    void'($urandom(32'hec32));
    repeat (2) @(posedge clock_i);
    resetn_i <= 1'b1;
    tick(0);
    chk({stby, reg_on, run, int_n}, 4'b1001, "reset state");
    @(posedge clock_i) {sen, cen} <= 2'b11;
    tick(10);
    chk({stby, reg_on, int_n, permit}, 4'b0100, "alive but unconfigured");
    @(posedge clock_i) cc <= 1'b1;
    tick(20);
    chk(run, 1'b0, "ran before setup-done");
    @(posedge clock_i) cc <= 1'b0;
    host.configure(32'h3);
    tick(4);
    chk({permit, int_n}, 2'b11, "permit after configure");
    host.xfer(1'b0, chg_seq_pkg::REG_CTRL, '0, q);
    chk(q, 32'h3, "ctrl readback");
    host.xfer(1'b0, 2'h2, '0, q);
    chk(q, 32'h0, "unmapped read");
    @(posedge clock_i) cc <= 1'b1; // legacy adapter termination looks the same
    wait_run(1'b1, n);
    chk({run, fet}, 2'b11, "attach starts converter");
    host.xfer(1'b0, chg_seq_pkg::REG_STATUS, '0, q);
    chk(q[4:0], 5'b01111, "status bits");
    // capability priority: all-on corner first, then random mixes
    for (int i = 0; i < 16; i++) begin
      c = (i == 0) ? 4'hf : 4'($urandom);
      @(posedge clock_i) {a3, a15, bc, u3} <= c;
      tick(4);
      chk(lvl, lvl_exp(c), "charge level");
    end
    @(posedge clock_i) cen <= 1'b0;
    tick(8);
    chk({permit, run}, 2'b00, "pin low overrides soft enable");
    @(posedge clock_i) cen <= 1'b1;
    wait_run(1'b1, n);
    chk(n >= 3950 && n <= 4050, 1'b1, "permit hold-off length");
    @(posedge clock_i) cc <= 1'b0;
    tick(8);
    chk({run, fet}, 2'b00, "detach stops drive");
    @(posedge clock_i) cc <= 1'b1;
    wait_run(1'b1, n);
    chk(n >= 3950 && n <= 4050, 1'b1, "detach hold-off length");
    host.configure(32'h1);
    tick(4);
    chk({permit, run}, 2'b00, "soft enable off");
    @(posedge clock_i) cc <= 1'b0;
    host.configure(32'h7);
    wait_run(1'b1, n);
    chk({run, n < 5000}, 2'b11, "bypass runs without attach");
    @(posedge clock_i) rail <= 1'b0;
    tick(8);
    chk({stby, run}, 2'b10, "rail undervoltage");
    @(posedge clock_i) rail <= 1'b1;
    tick(10);
    host.xfer(1'b0, chg_seq_pkg::REG_CTRL, '0, q);
    chk(int_n, 1'b0, "system reset raises interrupt");
    chk(q, 32'h0, "system reset clears control");
    @(posedge clock_i) {sen, cen, ser, sup} <= 4'b0001;
    tick(8);
    chk({reg_on, stby}, 2'b01, "enable low is standby");
    @(posedge clock_i) {sen, cc} <= 2'b11;
    tick(30);
    chk(run, 1'b0, "pin low at enable keeps off");
    @(posedge clock_i) cen <= 1'b1;
    wait_run(1'b1, n);
    chk({run, int_n}, 2'b10, "resistor variant runs on pin");
    @(posedge clock_i) sup <= 1'b0;
    tick(10);
    chk(reg_on, 1'b0, "supply under threshold");
    complete_run();
  end
endmodule : tb
